// ---- logic/owd_top.sv ----
/*
 * owd_top: option word latch and decode, self-write range check,
 * external read guard, user id words and identity word, ahb-lite slave.
 * assumes hclk domain inputs except flash_option_word, which is stable
 * nonvolatile content and is sampled once after reset release.
 */
// The AHB-Lite interface to the registers was decided locally.
// Operation
// - option word lives at 2007h, bit 13 always reads one
// - 256-word part range field protects none, 03Fh, 07Fh or 0FFh
// - 512-word part range field protects none, 07Fh, 0FFh or 1FFh
// - bit 10 set picks low brownout trip, clear picks high
// - bit 9 enables low-power brownout reset
// - bit 8 allows low-voltage programming and forces master clear
// - pin enable ignored under low-voltage programming, else selects pin use
// - bit 5 is active low power-up timer enable
// - brownout enable never turns on the power-up timer
// - watchdog mode field: on, run-only, software, off
// - brownout mode field; software bit used only in mode 01
// - bit 0 picks external clock, else internal oscillator
// - code protect blocks programmer access, reads return zero
// - cpu reads always allowed; cpu writes depend only on range
// - code protection cleared only by bulk erase; reset also clears it until the option word is latched after release
// - four user id words at 2000h-2003h readable and writable
// - identity word at 2006h: part id 13-5, revision 4-0
// - identity word is read-only, writes ignored
module owd_top
    import owd_pkg::*;
#(
    parameter bit         BIG_PART    = 1'b1,
    parameter logic [8:0] PART_ID     = 9'h0a5, // arbitrary value
    parameter logic [4:0] SILICON_REV = 5'h01   // arbitrary value
) (
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    // nonvolatile option word and erase event
    input  wire logic [13:0]   flash_option_word,
    input  wire logic          bulk_erase_done,
    // cpu self-write check
    input  wire logic          cpu_write_req,
    input  wire logic [9:0]    cpu_write_addr,
    output logic               cpu_write_allow,
    // soft enables from core control registers
    input  wire logic          watchdog_soft_enable,
    input  wire logic          brownout_soft_enable,
    // external programmer access
    input  owd_pkg::owd_prog_req_t prog_req,
    output owd_pkg::owd_prog_rsp_t prog_rsp,
    // decoded settings
    output owd_pkg::owd_cfg_t  cfg,
    output logic               watchdog_enabled,
    output logic               brownout_enabled
);
    import owd_pkg::*;

    typedef struct packed {
        logic        loaded;
        logic [13:0] option;
        owd_cfg_t    cfg;
        logic [3:0][13:0] uid;
        logic        dph;       // data phase pending
        logic        dwr;
        logic [15:0] daddr;
        logic [31:0] rdata;
        logic [9:0]  pgm_addr;
        logic [13:0] pgm_data;
        logic        allow;
        owd_prog_rsp_t prsp;
        logic        wdt_en;
        logic        bor_en;
    } owd_state_t;

    owd_state_t s_q, s_d;

    function automatic owd_cfg_t decode(input logic [13:0] w);
        owd_cfg_t c;
        logic [1:0] r;
        c = '0;
        r = w[OWD_WRT_LSB +: 2];
        unique case (r)
            2'b11: c.protect_top = 10'h000;
            2'b10: c.protect_top = BIG_PART ? 10'h07f : 10'h03f;
            2'b01: c.protect_top = BIG_PART ? 10'h0ff : 10'h07f;
            2'b00: c.protect_top = BIG_PART ? 10'h1ff : 10'h0ff;
        endcase
        c.protect_any = (r != 2'b11);
        c.brownout_voltage_low = w[OWD_BROWNOUT_VOLTAGE_SELECT_BIT];
        c.low_power_brownout_enable = w[OWD_LOW_POWER_BROWNOUT_ENABLE_BIT];
        c.low_voltage_program_enable = w[OWD_LVP_BIT];
        c.master_clear_active = w[OWD_LVP_BIT] | w[OWD_MASTER_CLEAR_PIN_ENABLE_BIT];
        c.master_clear_pullup = w[OWD_LVP_BIT] | w[OWD_MASTER_CLEAR_PIN_ENABLE_BIT];
        c.pin3_pullup_by_reg  = ~(w[OWD_LVP_BIT] | w[OWD_MASTER_CLEAR_PIN_ENABLE_BIT]);
        // timer from its own bit only
        c.powerup_timer_on = ~w[OWD_POWERUP_TIMER_ENABLE_N_BIT];
        c.watchdog_run   = w[OWD_WDT_LSB + 1];
        c.watchdog_sleep = w[OWD_WDT_LSB +: 2] == OWD_WDT_ON;
        c.brownout_run   = w[OWD_BOR_LSB + 1];
        c.brownout_sleep = w[OWD_BOR_LSB +: 2] == OWD_WDT_ON;
        c.external_clock_mode = w[OWD_FOSC_BIT];
        c.code_protect_on = ~w[OWD_CP_BIT];
        return c;
    endfunction : decode

    function automatic logic [13:0] rd_word(input owd_state_t s,
                                            input logic [15:0] a);
        logic [13:0] v;
        v = '0;
        if (a >= OWD_UID0_OFS && a <= OWD_UID3_OFS)
            v = s.uid[a[1:0]];
        else if (a == OWD_IDENT_OFS)
            v = {PART_ID, SILICON_REV};
        else if (a == OWD_OPTION_OFS)
            v = s.option | (14'h1 << OWD_TOP_BIT);
        else if (a == OWD_PGMADR_OFS)
            v = {4'h0, s.pgm_addr};
        else if (a == OWD_PGMDAT_OFS)
            v = s.pgm_data;
        else if (a == OWD_STAT_OFS)
            v = {11'h0, s.cfg.code_protect_on, s.wdt_en, s.bor_en};
        return v;
    endfunction : rd_word

    // every location is one word: the word index is the byte address / 4
    logic [15:0] idx;
    assign idx = haddr[17:2];

    always_comb begin
        s_d = s_q;
        if (!s_q.loaded) begin
            s_d.loaded = 1'b1;
            s_d.option = flash_option_word;
            s_d.cfg    = decode(flash_option_word);
        end
        if (bulk_erase_done) begin
            s_d.option = OWD_ERASED;
            s_d.cfg    = decode(OWD_ERASED);
        end
        // soft enable only in mode 01
        s_d.wdt_en = s_q.cfg.watchdog_run |
            (s_q.option[OWD_WDT_LSB +: 2] == OWD_WDT_SOFT &&
             watchdog_soft_enable);
        s_d.bor_en = s_q.cfg.brownout_run |
            (s_q.option[OWD_BOR_LSB +: 2] == OWD_WDT_SOFT &&
             brownout_soft_enable);
        // cpu write gated by range only
        s_d.allow = cpu_write_req &&
            !(s_q.cfg.protect_any && cpu_write_addr <= s_q.cfg.protect_top);
        s_d.prsp = '0;
        if (prog_req.req) begin
            s_d.prsp.ack = 1'b1;
            if (s_q.cfg.code_protect_on) begin
                s_d.prsp.refused = 1'b1;
            end else if (!prog_req.write) begin
                s_d.prsp.rdata = s_q.pgm_data;
            end else begin
                s_d.pgm_addr = prog_req.addr;
                s_d.pgm_data = prog_req.wdata;
            end
        end
        // ahb-lite data phase
        s_d.dph = 1'b0;
        if (s_q.dph && s_q.dwr) begin
            if (s_q.daddr >= OWD_UID0_OFS && s_q.daddr <= OWD_UID3_OFS)
                s_d.uid[s_q.daddr[1:0]] = hwdata[13:0];
            else if (s_q.daddr == OWD_PGMADR_OFS)
                s_d.pgm_addr = hwdata[9:0];
            else if (s_q.daddr == OWD_PGMDAT_OFS)
                s_d.pgm_data = hwdata[13:0];
        end
        if (hsel && hready && htrans[1]) begin
            s_d.dph   = 1'b1;
            s_d.dwr   = hwrite;
            s_d.daddr = idx;
            s_d.rdata = {18'h0, rd_word(s_q, idx)};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q        <= '0;
            s_q.option <= OWD_ERASED;
            s_q.cfg    <= decode(OWD_ERASED);
            s_q.uid    <= {4{OWD_UID_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata           = s_q.rdata;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign cpu_write_allow  = s_q.allow;
    assign prog_rsp         = s_q.prsp;
    assign cfg              = s_q.cfg;
    assign watchdog_enabled = s_q.wdt_en;
    assign brownout_enabled = s_q.bor_en;
    logic unused_ok;
    assign unused_ok = ^{haddr[31:18], haddr[1:0], hsize, hwdata[31:14]};

endmodule : owd_top

// ---- logic/owd_pkg.sv ----
/*
 * owd_pkg: constants and carrier types for the option word decoder.
 * assumes a single 100 MHz clock domain and an ahb-lite register bus.
 */
package owd_pkg;

    // program-space locations as word indices; byte address is index * 4
    localparam logic [15:0] OWD_UID0_OFS   = 16'h2000;
    localparam logic [15:0] OWD_UID3_OFS   = 16'h2003;
    localparam logic [15:0] OWD_IDENT_OFS  = 16'h2006;
    localparam logic [15:0] OWD_OPTION_OFS = 16'h2007;
    // own registers
    localparam logic [15:0] OWD_CTRL_OFS   = 16'h2010;
    localparam logic [15:0] OWD_STAT_OFS   = 16'h2014;
    localparam logic [15:0] OWD_PGMADR_OFS = 16'h2018;
    localparam logic [15:0] OWD_PGMDAT_OFS = 16'h201c;

    localparam logic [13:0] OWD_ERASED    = 14'h3fff;
    localparam logic [13:0] OWD_UID_RST   = 14'h3fff;
    localparam int          OWD_WRT_LSB   = 11;
    localparam int          OWD_BROWNOUT_VOLTAGE_SELECT_BIT  = 10;
    localparam int          OWD_LOW_POWER_BROWNOUT_ENABLE_BIT = 9;
    localparam int          OWD_LVP_BIT   = 8;
    localparam int          OWD_CP_BIT    = 7;
    localparam int          OWD_MASTER_CLEAR_PIN_ENABLE_BIT = 6;
    localparam int          OWD_POWERUP_TIMER_ENABLE_N_BIT = 5;
    localparam int          OWD_WDT_LSB   = 3;
    localparam int          OWD_BOR_LSB   = 1;
    localparam int          OWD_FOSC_BIT  = 0;
    localparam int          OWD_TOP_BIT   = 13;

    typedef enum logic [1:0] {
        OWD_WDT_OFF  = 2'b00,
        OWD_WDT_SOFT = 2'b01,
        OWD_WDT_RUN  = 2'b10,
        OWD_WDT_ON   = 2'b11
    } owd_mode_t;

    typedef struct packed {
        logic [9:0] protect_top;     // last protected address
        logic       protect_any;
        logic       brownout_voltage_low;
        logic       low_power_brownout_enable;
        logic       low_voltage_program_enable;
        logic       master_clear_active;
        logic       master_clear_pullup;
        logic       pin3_pullup_by_reg;
        logic       powerup_timer_on;
        logic       watchdog_run;
        logic       watchdog_sleep;
        logic       brownout_run;
        logic       brownout_sleep;
        logic       external_clock_mode;
        logic       code_protect_on;
    } owd_cfg_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [9:0]  addr;
        logic [13:0] wdata;
    } owd_prog_req_t;

    typedef struct packed {
        logic        ack;
        logic        refused;
        logic [13:0] rdata;
    } owd_prog_rsp_t;

endpackage : owd_pkg

// ---- sim/owd_check_sva.sv ----
/* owd_check_sva: port checks for owd_top.
   assumes one hclk domain, hresetn async active low. */
module owd_check_sva
    import owd_pkg::*;
#(
    parameter logic [8:0] PART_ID     = 9'h0a5, // arbitrary value
    parameter logic [4:0] SILICON_REV = 5'h01   // arbitrary value
) (
    // clock, reset and bus
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic         hready,
    input  wire logic [31:0]  hrdata,
    // protection and settings
    input  wire logic         bulk_erase_done,
    input  wire logic         cpu_write_req,
    input  wire logic [9:0]   cpu_write_addr,
    input  wire logic         cpu_write_allow,
    input  owd_pkg::owd_prog_req_t prog_req,
    input  owd_pkg::owd_prog_rsp_t prog_rsp,
    input  owd_pkg::owd_cfg_t cfg
);
    logic rd_go;
    logic in_range;
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign in_range = cfg.protect_any && cpu_write_addr <= cfg.protect_top;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ident_read_a: assert property (rd_go && haddr == 32'h8018 |=>
        hrdata == {18'h0, PART_ID, SILICON_REV}) else $error("bad ident");
    option_top_a: assert property (rd_go && haddr == 32'h801c |=>
        hrdata[13] && hrdata[31:14] == 18'h0) else $error("bad option");
    prog_block_a: assert property (prog_req.req && cfg.code_protect_on |=>
        prog_rsp.ack && prog_rsp.refused && prog_rsp.rdata == 14'h0)
        else $error("access not refused");
    prog_open_a: assert property (prog_req.req && !cfg.code_protect_on |=>
        prog_rsp.ack && !prog_rsp.refused) else $error("access refused");
    self_deny_a: assert property (cpu_write_req && in_range |=>
        !cpu_write_allow) else $error("protected write allowed");
    self_allow_a: assert property (cpu_write_req && !in_range |=>
        cpu_write_allow) else $error("open write denied");
    cfg_hold_a: assert property ($past(hresetn, 3) &&
        !$past(bulk_erase_done) && !$past(bulk_erase_done, 2) |->
        $stable(cfg)) else $error("settings changed");
    erase_clear_a: assert property (bulk_erase_done |-> ##[1:3]
        (!cfg.code_protect_on && !cfg.protect_any)) else $error("no clear");
    cover property (prog_req.req && cfg.code_protect_on);
    cover property (cpu_write_req && in_range);
    cover property (bulk_erase_done);
endmodule : owd_check_sva

bind owd_top owd_check_sva #(.PART_ID(PART_ID),
    .SILICON_REV(SILICON_REV)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .bulk_erase_done(bulk_erase_done), .cpu_write_req(cpu_write_req),
    .cpu_write_addr(cpu_write_addr), .cpu_write_allow(cpu_write_allow),
    .prog_req(prog_req), .prog_rsp(prog_rsp), .cfg(cfg));

// ---- sim/owd_prog_model.sv ----
/* owd_prog_model: external programmer issuing single accesses.
   assumes the answer stands for the cycle after the request edge. */
module owd_prog_model
    import owd_pkg::*;
(
    // clock and access port
    input  wire logic              hclk,
    output owd_pkg::owd_prog_req_t prog_req,
    input  owd_pkg::owd_prog_rsp_t prog_rsp
);
    initial prog_req = '0;
    task automatic access(input logic w, input logic [9:0] a,
                          input logic [13:0] d, output owd_prog_rsp_t r);
        prog_req <= '{req: 1'b1, write: w, addr: a, wdata: d};
        @(posedge hclk);
        // released lines show inverted values
        prog_req <= '{req: 1'b0, write: !w, addr: ~a, wdata: ~d};
        // answer settled mid-cycle, before it drops at the next edge
        @(negedge hclk);
        r = prog_rsp;
    endtask : access
endmodule : owd_prog_model

// ---- sim/tb_option_word_decode_protect.sv ----
/* tb_option_word_decode_protect: self-checking bench for owd_top.
   assumes owd_top, owd_prog_model and the bound checker. */
module tb_option_word_decode_protect import owd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [8:0] ID = 9'h0c3; // arbitrary value
    localparam logic [4:0] RV = 5'h0a;  // arbitrary value
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, r;
    logic [1:0] htrans = '0;
    logic hreadyout, hresp, bulk_erase_done = 1'b0, cpu_write_allow;
    logic cpu_write_req = 1'b0, wdt_soft = 1'b0, bor_soft = 1'b0;
    logic [9:0] cpu_write_addr = '0, a;
    logic [13:0] flash_word = 14'h3fff, w, u;
    owd_prog_req_t prog_req;
    owd_prog_rsp_t prog_rsp, rsp;
    owd_cfg_t cfg, e, m;
    int mismatches = 0, comparisons = 0, cycles = 0;
    always #5 hclk = ~hclk;
    owd_top #(.PART_ID(ID), .SILICON_REV(RV)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .flash_option_word(flash_word),
        .bulk_erase_done(bulk_erase_done), .cpu_write_req(cpu_write_req),
        .cpu_write_addr(cpu_write_addr), .cpu_write_allow(cpu_write_allow),
        .watchdog_soft_enable(wdt_soft), .brownout_soft_enable(bor_soft),
        .prog_req(prog_req), .prog_rsp(prog_rsp), .cfg(cfg),
        .watchdog_enabled(), .brownout_enabled());
    owd_prog_model u_prog (.hclk(hclk), .prog_req(prog_req),
        .prog_rsp(prog_rsp));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [15:0] ad,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {14'h0, ad, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(22));
        for (int k = 0; k < 4; k++) begin
            r = $urandom();
            u = 14'(r >> 9);
            w = {1'b1, k[1:0], r[2:0], !k[0], r[3], r[4], k[1:0], k[1:0], r[5]};
            @(posedge hclk);
            hresetn <= 1'b0;
            flash_word <= w;
            wdt_soft <= r[6];
            bor_soft <= r[7];
            repeat (2) @(posedge hclk);
            hresetn <= 1'b1;
            repeat (3) @(posedge hclk);
            bus(1'b0, 16'h2000, '0);
            if (k == 0) check(rd, 32'h3fff);
            bus(1'b1, 16'h2000, {18'h0, u});
            bus(1'b1, 16'h2003, {18'h0, ~u});
            bus(1'b0, 16'h2003, '0);
            check(rd, {18'h0, ~u});
            bus(1'b1, 16'h2006, 32'hffff_ffff);
            bus(1'b1, 16'h2007, 32'h0);
            bus(1'b0, 16'h2000, '0);
            check(rd, {18'h0, u});
            bus(1'b0, 16'h2006, '0);
            check(rd, {18'h0, ID, RV});
            bus(1'b0, 16'h2007, '0);
            check(rd, {18'h0, w});
            bus(1'b0, 16'h2014, '0);
            check(rd, {29'h0, !w[7], w[4] | w[3] & r[6], w[2] | w[1] & r[7]});
            e = '0;
            e.protect_any = (k != 3);
            e.protect_top = (10'h200 >> k) - 10'h1;
            e.brownout_voltage_low = w[10];
            e.low_power_brownout_enable = w[9];
            e.low_voltage_program_enable = w[8];
            e.master_clear_active = w[8] | w[6];
            e.master_clear_pullup = w[8] | w[6];
            e.pin3_pullup_by_reg = !(w[8] | w[6]);
            e.powerup_timer_on = !w[5];
            e.watchdog_run = w[4];
            e.watchdog_sleep = &w[4:3];
            e.brownout_run = w[2];
            e.brownout_sleep = &w[2:1];
            e.external_clock_mode = w[0];
            e.code_protect_on = !w[7];
            m = '1;
            m.protect_top = {10{k != 3}};
            m.master_clear_pullup = !w[8];
            check(32'(cfg & m), 32'(e & m));
            for (int j = 0; j < 3; j++) begin
                a = (j == 2) ? 10'($urandom()) : e.protect_top + 10'(j);
                cpu_write_req <= 1'b1;
                cpu_write_addr <= a;
                @(posedge hclk);
                cpu_write_req <= 1'b0;
                #1 check(cpu_write_allow, !(k != 3 && a <= e.protect_top));
            end
            u_prog.access(r[8], 10'(r), 14'(r >> 4), rsp);
            check({rsp.ack, rsp.refused}, {1'b1, !w[7]});
            if (!w[7]) check(rsp.rdata, 14'h0);
        end
        @(posedge hclk);
        bulk_erase_done <= 1'b1;
        @(posedge hclk);
        bulk_erase_done <= 1'b0;
        repeat (3) @(posedge hclk);
        u_prog.access(1'b0, 10'h0, 14'h0, rsp);
        check(rsp.refused, 1'b0);
        bus(1'b0, 16'h2007, '0);
        check(rd, 32'h3fff);
        report_and_stop();
    end
endmodule : tb_option_word_decode_protect
